// File: core/warmup_params.svh
/*
 * Offsets, field positions, reset values and scale factors of the
 * serializer warm-up timer. Assumes inclusion by bare name from core/.
 */
`ifndef WARMUP_PARAMS_SVH
`define WARMUP_PARAMS_SVH

// Register offsets on the special function register bus
`define WU_ADDR_DIV_AMP   8'hAE
`define WU_ADDR_OSC       8'hAF

// Reset values
`define WU_RESET_DIV_AMP  8'h00
`define WU_RESET_OSC      8'h00

// Field positions
`define WU_DIV_MSB        7
`define WU_DIV_LSB        4
`define WU_AMP_MSB        3
`define WU_AMP_LSB        0
`define WU_OSC_MSB        3
`define WU_OSC_LSB        0

// Writable bits of the oscillator register, rest reads as zero
`define WU_OSC_WR_MASK    8'h0F

// Serializer clock cycles per count unit
`define WU_DIV_SCALE      4
`define WU_AMP_SCALE      1
`define WU_OSC_SCALE      64

// Widest interval: 64 x 15 = 960 cycles
`define WU_MAX_CYCLES     960

// Number of warmed blocks
`define WU_CHANNELS       3

`endif

// File: core/warmup_pkg.sv
/*
 * Types of the serializer warm-up timer.
 * Assumes warmup_params.svh holds the numbers.
 */
`default_nettype none

package warmup_pkg;

    // Sequencer state of the warm-up timer
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WARM
    } warm_state_t;

    // Channel index into the per-block counters
    typedef enum logic [1:0] {
        CH_DIV,
        CH_AMP,
        CH_OSC
    } warm_channel_t;

endpackage

`default_nettype wire

// File: core/serializer_clock_divider.sv
/*
 * Serializer clock enable generator: one tick every divisor+1 system
 * clocks. Assumes the divisor input is on the same clock as clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module serializer_clock_divider #(
    parameter int DIV_W = 3
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // Control
    input  wire logic [DIV_W-1:0] divisor_in,
    input  wire logic             restart_in,
    // Serializer clock tick
    output logic                  tick_out
);

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic             tick_q;
    logic             tick_d;

    generate
        if (DIV_W < 1) begin : g_chk
            $error("serializer_clock_divider: DIV_W must be at least 1");
        end
    endgenerate

    // Restart aligns the first tick to the trigger, divisor+1 clocks later
    always_comb begin
        cnt_d  = cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
        tick_d = 1'b0;
        if (restart_in) begin
            cnt_d = '0;
        end else if (cnt_q >= divisor_in) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
    end

    // Registered so the tick is glitch free
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_out = tick_q;

endmodule

`default_nettype wire

// File: core/serializer_warmup_timing.sv
/*
 * Warm-up timer of the output data serializer: times the bias-up
 * intervals of the carrier divider, the power amplifier and the tank
 * oscillator before transmission and on each OOK zero-to-one change.
 * Assumes the SFR bus, the serializer controls and the divisor field
 * all come from logic on clk_in.
 */

// Overview of operation
// - The divider is biased for four times its 4-bit count in serializer clock cycles.
// - The amplifier is biased for its 4-bit count taken directly in serializer clock cycles.
// - The tank oscillator is biased for sixty-four times its 4-bit count in serializer clock cycles.
// - Every interval runs before a transmission and again on each OOK zero-to-one symbol change.
// - The upper nibble of the oscillator register reads zero and ignores writes.
// - The serializer clock is the system clock divided by the divisor field plus one, one to eight.
`timescale 1ns/1ps
`default_nettype none
`include "warmup_params.svh"

module serializer_warmup_timing #(
    parameter int CNT_W = 10,
    parameter int DIV_W = 3
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // Special function register bus
    input  wire logic [7:0]       sfr_addr_in,
    input  wire logic             sfr_wr_in,
    input  wire logic             sfr_rd_in,
    input  wire logic [7:0]       sfr_wdata_in,
    output logic [7:0]            sfr_rdata_out,
    // Serializer control
    input  wire logic [DIV_W-1:0] serializer_clock_divisor_in,
    input  wire logic             tx_start_in,
    input  wire logic             ook_mode_in,
    input  wire logic             symbol_strobe_in,
    input  wire logic             symbol_bit_in,
    // Bias controls and status
    output logic                  div_warm_out,
    output logic                  amp_warm_out,
    output logic                  osc_warm_out,
    output logic                  warm_busy_out,
    output logic                  warm_done_out
);

    // One counter per warmed block, all three run in parallel
    localparam int NCH = `WU_CHANNELS;

    // Register file
    logic [7:0]                warm_div_amp_q;
    logic [7:0]                warm_div_amp_d;
    logic [7:0]                warm_osc_q;
    logic [7:0]                warm_osc_d;
    logic [7:0]                rdata_q;
    logic [7:0]                rdata_d;

    // Sequencer
    warmup_pkg::warm_state_t   state_q;
    warmup_pkg::warm_state_t   state_d;
    logic                      prev_bit_q;
    logic                      prev_bit_d;
    logic                      done_q;
    logic                      done_d;
    logic                      trigger;
    logic                      tick;
    logic                      any_warm;

    // Per-block counters
    logic [CNT_W-1:0]          load_val [NCH];
    logic [CNT_W-1:0]          cnt_q    [NCH];
    logic [CNT_W-1:0]          cnt_d    [NCH];
    logic [NCH-1:0]            warm;

    // Refuse widths the counters or the divider cannot serve
    generate
        if (CNT_W < $clog2(`WU_MAX_CYCLES + 1)) begin : g_chk_cnt
            $error("serializer_warmup_timing: CNT_W too small for the oscillator interval");
        end
        if (DIV_W != 3) begin : g_chk_div
            $error("serializer_warmup_timing: DIV_W must be 3 for division by one to eight");
        end
    endgenerate

    // Register writes and registered read data
    always_comb begin
        warm_div_amp_d = warm_div_amp_q;
        warm_osc_d     = warm_osc_q;
        rdata_d        = rdata_q;
        if (sfr_wr_in && sfr_addr_in == `WU_ADDR_DIV_AMP) begin
            warm_div_amp_d = sfr_wdata_in;
        end
        if (sfr_wr_in && sfr_addr_in == `WU_ADDR_OSC) begin
            warm_osc_d = sfr_wdata_in & `WU_OSC_WR_MASK;
        end
        if (sfr_rd_in) begin
            unique case (sfr_addr_in)
                `WU_ADDR_DIV_AMP: rdata_d = warm_div_amp_q;
                `WU_ADDR_OSC:     rdata_d = warm_osc_q & `WU_OSC_WR_MASK;
                default:          rdata_d = 8'h00; // Unmapped reads as zero
            endcase
        end
    end

    // Register file flops; read data holds until the next read
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            warm_div_amp_q <= `WU_RESET_DIV_AMP;
            warm_osc_q     <= `WU_RESET_OSC;
            rdata_q        <= 8'h00;
        end else begin
            warm_div_amp_q <= warm_div_amp_d;
            warm_osc_q     <= warm_osc_d;
            rdata_q        <= rdata_d;
        end
    end

    // Serializer clock tick, restarted so each interval begins aligned
    serializer_clock_divider #(
        .DIV_W (DIV_W)
    ) u_ser_clk (
        .clk_in     (clk_in),
        .resetn_in  (resetn_in),
        .divisor_in (serializer_clock_divisor_in),
        .restart_in (trigger),
        .tick_out   (tick)
    );

    // Start of transmission or an OOK zero-to-one change
    assign trigger = tx_start_in
                   || (ook_mode_in && symbol_strobe_in && symbol_bit_in && !prev_bit_q);

    // Interval lengths in serializer cycles
    assign load_val[warmup_pkg::CH_DIV] =
        CNT_W'(`WU_DIV_SCALE * warm_div_amp_q[`WU_DIV_MSB:`WU_DIV_LSB]);
    assign load_val[warmup_pkg::CH_AMP] =
        CNT_W'(`WU_AMP_SCALE * warm_div_amp_q[`WU_AMP_MSB:`WU_AMP_LSB]);
    assign load_val[warmup_pkg::CH_OSC] =
        CNT_W'(`WU_OSC_SCALE * warm_osc_q[`WU_OSC_MSB:`WU_OSC_LSB]);

    // One down counter per warmed block
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            always_comb begin
                cnt_d[gi] = cnt_q[gi];
                if (trigger) begin
                    cnt_d[gi] = load_val[gi];
                end else if (tick && cnt_q[gi] != '0) begin
                    cnt_d[gi] = cnt_q[gi] - CNT_W'(1);
                end
            end

            // Counter flops; a reload beats a pending tick
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    cnt_q[gi] <= '0;
                end else begin
                    cnt_q[gi] <= cnt_d[gi];
                end
            end

            // A zero count never raises the warm flag
            assign warm[gi] = (cnt_q[gi] != '0);
        end
    endgenerate

    assign any_warm = |warm;

    // Sequencer: busy while any block warms, done pulse when all finish
    always_comb begin
        state_d    = state_q;
        prev_bit_d = prev_bit_q;
        done_d     = 1'b0;
        if (tx_start_in) begin
            prev_bit_d = 1'b1; // Start already covers the first symbol
        end else if (symbol_strobe_in) begin
            prev_bit_d = symbol_bit_in;
        end
        unique case (state_q)
            warmup_pkg::ST_IDLE: begin
                if (trigger) begin
                    state_d = warmup_pkg::ST_WARM;
                end
            end
            warmup_pkg::ST_WARM: begin
                // All zero counts finish at once, no delay
                if (!trigger && !any_warm) begin
                    state_d = warmup_pkg::ST_IDLE;
                    done_d  = 1'b1;
                end
            end
        endcase
    end

    // Sequencer flops; last symbol starts high so reset fakes no rising edge
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q    <= warmup_pkg::ST_IDLE;
            prev_bit_q <= 1'b1;
            done_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            prev_bit_q <= prev_bit_d;
            done_q     <= done_d;
        end
    end

    // Outputs
    // Bias flags come from counter compares, free of the tick path
    assign sfr_rdata_out = rdata_q;
    assign div_warm_out  = warm[warmup_pkg::CH_DIV];
    assign amp_warm_out  = warm[warmup_pkg::CH_AMP];
    assign osc_warm_out  = warm[warmup_pkg::CH_OSC];
    assign warm_busy_out = (state_q == warmup_pkg::ST_WARM);
    assign warm_done_out = done_q;

endmodule

`default_nettype wire

// File: verification/warm_bias_model.sv
/* Far-side model of the divider, amplifier and tank oscillator bias.
   Assumes the bias flags are levels on clk_in; clear_in restarts counts. */
`timescale 1ns/1ps
`default_nettype none
module warm_bias_model (
    // Clock and count restart
    input  wire logic clk_in,
    input  wire logic clear_in,
    // Bias requests from the timer
    input  wire logic div_warm_in,
    input  wire logic amp_warm_in,
    input  wire logic osc_warm_in,
    // Cycles spent biased since the last restart
    output var int    len_div_out,
    output var int    len_amp_out,
    output var int    len_osc_out
);
    // Bias time adds up, so a second warm-up shows as extra length
    always_ff @(posedge clk_in) begin
        len_div_out <= clear_in ? 0 : len_div_out + int'(div_warm_in);
        len_amp_out <= clear_in ? 0 : len_amp_out + int'(amp_warm_in);
        len_osc_out <= clear_in ? 0 : len_osc_out + int'(osc_warm_in);
    end
endmodule
`default_nettype wire

// File: verification/warmup_monitor.sv
/* Port checker of the warm-up timer, bound to its top module.
   Assumes one clock domain and single-cycle bus strobes. */
`timescale 1ns/1ps
`default_nettype none
module warmup_monitor (
    // Clock, reset and register bus
    input wire logic       clk_in,
    input wire logic       resetn_in,
    input wire logic       sfr_wr_in,
    input wire logic       sfr_rd_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    // Serializer control
    input wire logic [2:0] serializer_clock_divisor_in,
    input wire logic       tx_start_in,
    input wire logic       ook_mode_in,
    input wire logic       symbol_strobe_in,
    input wire logic       symbol_bit_in,
    // Bias flags and status
    input wire logic       div_warm_out,
    input wire logic       amp_warm_out,
    input wire logic       osc_warm_out,
    input wire logic       warm_busy_out,
    input wire logic       warm_done_out
);
    logic [7:0] cnt_q;
    logic [3:0] osc_q;
    logic [7:0] len_q;
    logic       prev_q;
    wire        trig = tx_start_in || (ook_mode_in && symbol_strobe_in && symbol_bit_in && !prev_q);
    // Shadow counts and last symbol, so a trigger's load is known
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_q <= 8'h00;
            osc_q <= 4'h0;
            len_q <= 8'h00;
            prev_q <= 1'b1;
        end else begin
            if (sfr_wr_in && sfr_addr_in == 8'hAE) cnt_q <= sfr_wdata_in;
            if (sfr_wr_in && sfr_addr_in == 8'hAF) osc_q <= sfr_wdata_in[3:0];
            if (tx_start_in) prev_q <= 1'b1;
            else if (symbol_strobe_in) prev_q <= symbol_bit_in;
            // A reload restarts the length, since a retrigger may rightly stretch the bias
            len_q <= (amp_warm_out && !trig) ? len_q + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    a_div_starts: assert property (trig && cnt_q[7:4] != 4'h0 |=> div_warm_out)
        else $error("divider bias missing after trigger");
    a_amp_starts: assert property (trig && cnt_q[3:0] != 4'h0 |=> amp_warm_out)
        else $error("amplifier bias missing after trigger");
    a_osc_starts: assert property (trig && osc_q != 4'h0 |=> osc_warm_out)
        else $error("oscillator bias missing after trigger");
    a_zero_quiet: assert property (trig && cnt_q[3:0] == 4'h0 |=> !amp_warm_out)
        else $error("amplifier biased with zero count");
    a_trig_busy: assert property (trig && cnt_q != 8'h00 |=> warm_busy_out)
        else $error("busy missing after trigger");
    a_warm_in_busy: assert property (div_warm_out || amp_warm_out || osc_warm_out |-> warm_busy_out)
        else $error("bias flag outside busy");
    a_done_after: assert property ($fell(warm_busy_out) |-> ##[0:1] warm_done_out)
        else $error("done pulse missing");
    a_amp_bound: assert property (len_q <= 8'h79)
        else $error("amplifier bias too long");
    a_osc_upper: assert property (sfr_rd_in && sfr_addr_in == 8'hAF |=> sfr_rdata_out[7:4] == 4'h0)
        else $error("upper oscillator bits not zero");
    a_rdata_hold: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
        else $error("read data moved without read");
    c_start: cover property (tx_start_in ##1 warm_busy_out);
    c_retrig: cover property (trig && !tx_start_in);
    c_done: cover property (warm_done_out);
endmodule
bind serializer_warmup_timing warmup_monitor mon (.clk_in, .resetn_in, .sfr_wr_in, .sfr_rd_in, .sfr_addr_in,
    .sfr_wdata_in, .sfr_rdata_out, .serializer_clock_divisor_in, .tx_start_in, .ook_mode_in,
    .symbol_strobe_in, .symbol_bit_in, .div_warm_out, .amp_warm_out, .osc_warm_out, .warm_busy_out,
    .warm_done_out);
`default_nettype wire

// File: verification/test_serializer_warmup_timing.sv
/* Self-checking bench of the warm-up timer with a bias model.
   Assumes the design under core/ and the monitor bound to it. */
`timescale 1ns/1ps
`default_nettype none
module test_serializer_warmup_timing;
    logic clk_in = 1'b0, resetn_in = 1'b0, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, clr = 1'b0;
    logic tx_start_in = 1'b0, ook_mode_in = 1'b0, symbol_strobe_in = 1'b0, symbol_bit_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out;
    logic [2:0] serializer_clock_divisor_in = 3'h0;
    logic div_warm_out, amp_warm_out, osc_warm_out, warm_busy_out, warm_done_out;
    logic [15:0] rv;
    int n_errors = 0, n_compared = 0, cycles = 0, len_div, len_amp, len_osc;
    int seed = 32'h61926e77;
    always #20 clk_in = ~clk_in;
    serializer_warmup_timing dut (.clk_in, .resetn_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in,
        .sfr_rdata_out, .serializer_clock_divisor_in, .tx_start_in, .ook_mode_in, .symbol_strobe_in,
        .symbol_bit_in, .div_warm_out, .amp_warm_out, .osc_warm_out, .warm_busy_out, .warm_done_out);
    warm_bias_model bias (.clk_in, .clear_in(clr), .div_warm_in(div_warm_out), .amp_warm_in(amp_warm_out),
        .osc_warm_in(osc_warm_out), .len_div_out(len_div), .len_amp_out(len_amp), .len_osc_out(len_osc));
    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Range compare; an unknown never lands inside the range
    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        n_compared++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    // Bias length: n ticks of divisor+1 clocks plus the one register stage
    function automatic int exp_len(input int n);
        return n * (int'(serializer_clock_divisor_in) + 1) + ((n > 0) ? 1 : 0);
    endfunction
    task automatic chk_len(input int got, input int n);
        int e;
        e = exp_len(n);
        chk(got[15:0], e[15:0], e[15:0]);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_in) s = 1'b1;
        @(negedge clk_in) s = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        pulse(sfr_wr_in);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        sfr_addr_in = a;
        pulse(sfr_rd_in);
        chk(16'(sfr_rdata_out), 16'(e), 16'(e));
    endtask
    // A done pulse that never comes counts as a mismatch
    task automatic wait_done();
        int k;
        for (k = 0; k < 8000 && warm_done_out !== 1'b1; k++) @(negedge clk_in);
        if (k == 8000) n_errors++;
        @(negedge clk_in);
    endtask
    // Start, optionally one OOK zero-to-one retrigger, then a symbol strobe that must not retrigger, a one-to-one in OOK runs
    task automatic run(input logic [2:0] d, input logic [3:0] a, b, c, input logic ook);
        serializer_clock_divisor_in = d;
        ook_mode_in = ook;
        wr(8'hAE, {a, b});
        wr(8'hAF, {4'hA, c});
        rd_chk(8'hAE, {a, b});
        rd_chk(8'hAF, {4'h0, c});
        for (int r = 0; r <= int'(ook); r++) begin
            clr = 1'b1;
            if (r == 0) pulse(tx_start_in);
            else begin
                symbol_bit_in = 1'b0;
                pulse(symbol_strobe_in);
                symbol_bit_in = 1'b1;
                pulse(symbol_strobe_in);
            end
            clr = 1'b0;
            wait_done();
            chk_len(len_div, 4 * int'(a));
            chk_len(len_amp, int'(b));
            chk_len(len_osc, 64 * int'(c));
        end
        pulse(symbol_strobe_in);
        chk(16'(warm_busy_out), 16'h0, 16'h0);
    endtask
    // Hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 50000) begin
            n_errors++;
            end_sim();
        end
    end
    // Reset, register checks, corner cases, then seeded random runs
    initial begin
        repeat (5) @(negedge clk_in);
        resetn_in = 1'b1;
        rd_chk(8'hAE, 8'h00);
        rd_chk(8'hAF, 8'h00);
        wr(8'hAA, 8'h5A);
        rd_chk(8'hAA, 8'h00);
        run(3'h0, 4'h0, 4'h0, 4'h0, 1'b0);
        run(3'h7, 4'hF, 4'hF, 4'h1, 1'b1);
        run(3'h0, 4'h1, 4'h1, 4'h0, 1'b1);
        run(3'h7, 4'h0, 4'h0, 4'hF, 1'b0);
        for (int i = 0; i < 8; i++) begin
            rv = 16'($random(seed));
            run(rv[2:0], rv[7:4], rv[11:8], {2'b00, rv[13:12]}, rv[14]);
        end
        end_sim();
    end
endmodule
`default_nettype wire
